/* irq_bank_consts.vh */
// Register offsets, bit positions and reset values of the peripheral interrupt bank
`ifndef IRQ_BANK_CONSTS_VH
`define IRQ_BANK_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_FLAGS_1 12'h000
`define OFS_FLAGS_2 12'h004
`define OFS_FLAGS_3 12'h008
`define OFS_ENABLES_1 12'h00C
`define OFS_ENABLES_2 12'h010
`define OFS_ENABLES_3 12'h014
`define OFS_PRIORITY_1 12'h018
`define OFS_PRIORITY_2 12'h01C
`define OFS_PRIORITY_3 12'h020
`define OFS_CORE_CTRL 12'h024
`define OFS_STATUS 12'h028

// ----------------------------------------
// Implemented-bit masks, MASK_3 less read-only bit 4 (unimplemented bits read zero)
// ----------------------------------------
`define MASK_1 8'hFF
`define MASK_2 8'hCF
`define MASK_3 8'h21
// Read-only buffer-state flags (serial receive/transmit)
`define RO_1 8'h30
`define RO_3 8'h30
// Full implemented set of group 3 including read-only flags
`define IMPL_3 8'h31

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_PRIO_1 8'hFF
`define RST_PRIO_2 8'hCF
`define RST_PRIO_3 8'h31
`define RST_CTRL 4'h0

// ----------------------------------------
// Core control bit positions
// ----------------------------------------
`define CTRL_GLOBAL 0
`define CTRL_PERIPH 1
`define CTRL_PRIO 2
`define CTRL_W 4

`endif

/* peripheral_irq_flag_enable_bank.v */
// Peripheral interrupt flag and enable bank with an APB register slave
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`include "irq_bank_consts.vh"
module peripheral_irq_flag_enable_bank (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Peripheral set pulses, one per flag position
	input wire [7:0] set_events_1,
	input wire [7:0] set_events_2,
	input wire [7:0] set_events_3,
	// Serial buffer levels: bit 5 rx full, bit 4 tx empty
	input wire [7:0] buffer_state_1,
	input wire [7:0] buffer_state_3,
	output reg high_priority_request,
	output reg low_priority_request
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [7:0] flags_1_q;
	reg [7:0] flags_2_q;
	reg [7:0] flags_3_q;
	reg [7:0] enables_1_q;
	reg [7:0] enables_2_q;
	reg [7:0] enables_3_q;
	reg [7:0] priority_1_q;
	reg [7:0] priority_2_q;
	reg [7:0] priority_3_q;
	reg [`CTRL_W-1:0] ctrl_q;
	reg [7:0] buf_1_q;
	reg [7:0] buf_3_q;
	reg [7:0] flags_1_d;
	reg [7:0] flags_2_d;
	reg [7:0] flags_3_d;
	reg [31:0] rdata_d;
	reg hit_d;
	wire wr_acc;
	wire rd_acc;
	wire [7:0] wbyte;
	wire [7:0] req_1;
	wire [7:0] req_2;
	wire [7:0] req_3;
	wire global_irq_enable;
	wire peripheral_group_enable;
	wire priority_levels_on;
	wire any_high;
	wire any_low;
	wire hi_d;
	wire lo_d;

	// Act only in the first access cycle; a write repeated in the wait cycle would
	// wipe out a flag event that arrived between the two access edges
	assign wr_acc = psel & penable & pwrite & ~pready;
	assign rd_acc = psel & penable & ~pwrite & ~pready;
	assign wbyte = pwdata[7:0];
	assign global_irq_enable = ctrl_q[`CTRL_GLOBAL];
	assign peripheral_group_enable = ctrl_q[`CTRL_PERIPH];
	assign priority_levels_on = ctrl_q[`CTRL_PRIO];

	// ----------------------------------------
	// Buffer level synchronisers
	// ----------------------------------------
	// Serial buffer levels come from other logic on this clock, so one stage suffices
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_1_q <= `RST_BYTE;
			buf_3_q <= `RST_BYTE;
		end else begin
			buf_1_q <= buffer_state_1 & `RO_1;
			buf_3_q <= buffer_state_3 & `RO_3;
		end
	end

	// ----------------------------------------
	// Flag next-state
	// ----------------------------------------
	// Clear by writing zero, then OR in events so a same-cycle event is kept
	always @* begin
		flags_1_d = flags_1_q;
		flags_2_d = flags_2_q;
		flags_3_d = flags_3_q;
		if (wr_acc && paddr == `OFS_FLAGS_1) begin
			flags_1_d = flags_1_q & wbyte;
		end else if (wr_acc && paddr == `OFS_FLAGS_2) begin
			flags_2_d = flags_2_q & wbyte;
		end else if (wr_acc && paddr == `OFS_FLAGS_3) begin
			flags_3_d = flags_3_q & wbyte;
		end
		// Sticky event flags, set whatever the enables say
		flags_1_d = ((flags_1_d | set_events_1) & ~`RO_1) | buf_1_q;
		flags_2_d = (flags_2_d | set_events_2) & `MASK_2;
		// Serial flags mirror the buffer level, so a buffer access clears them
		flags_3_d = ((flags_3_d | set_events_3) & `MASK_3 & ~`RO_3) | buf_3_q;
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_1_q <= `RST_BYTE;
			flags_2_q <= `RST_BYTE;
			flags_3_q <= `RST_BYTE;
			enables_1_q <= `RST_BYTE;
			enables_2_q <= `RST_BYTE;
			enables_3_q <= `RST_BYTE;
			priority_1_q <= `RST_PRIO_1;
			priority_2_q <= `RST_PRIO_2;
			priority_3_q <= `RST_PRIO_3;
			ctrl_q <= `RST_CTRL;
		end else begin
			flags_1_q <= flags_1_d;
			flags_2_q <= flags_2_d;
			flags_3_q <= flags_3_d;
			if (wr_acc) begin
				if (paddr == `OFS_ENABLES_1) begin
					enables_1_q <= wbyte;
				end else if (paddr == `OFS_ENABLES_2) begin
					enables_2_q <= wbyte & `MASK_2;
				end else if (paddr == `OFS_ENABLES_3) begin
					// Serial B enables are writable too, though their flags are not
					enables_3_q <= wbyte & `IMPL_3;
				end else if (paddr == `OFS_PRIORITY_1) begin
					priority_1_q <= wbyte;
				end else if (paddr == `OFS_PRIORITY_2) begin
					priority_2_q <= wbyte & `MASK_2;
				end else if (paddr == `OFS_PRIORITY_3) begin
					priority_3_q <= wbyte & `IMPL_3;
				end else if (paddr == `OFS_CORE_CTRL) begin
					ctrl_q <= pwdata[`CTRL_W-1:0];
				end
			end
		end
	end

	// ----------------------------------------
	// Request gating
	// ----------------------------------------
	// Flag AND enable, aligned bit for bit
	assign req_1 = flags_1_q & enables_1_q;
	assign req_2 = flags_2_q & enables_2_q;
	assign req_3 = flags_3_q & enables_3_q;
	// Split by priority bit; with priorities off every source counts as low group
	assign any_high = priority_levels_on &
		(|(req_1 & priority_1_q) | |(req_2 & priority_2_q) | |(req_3 & priority_3_q));
	assign any_low = |(req_1 & ~(priority_1_q & {8{priority_levels_on}})) |
		|(req_2 & ~(priority_2_q & {8{priority_levels_on}})) |
		|(req_3 & ~(priority_3_q & {8{priority_levels_on}}));
	// Priorities off: group enable and global enable both needed
	// Priorities on: the same bit acts as the low-level global enable
	assign hi_d = any_high & global_irq_enable;
	assign lo_d = any_low & peripheral_group_enable & global_irq_enable;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		rdata_d = 32'h00000000;
		hit_d = 1'b1;
		if (paddr == `OFS_FLAGS_1) begin
			rdata_d[7:0] = flags_1_q;
		end else if (paddr == `OFS_FLAGS_2) begin
			rdata_d[7:0] = flags_2_q;
		end else if (paddr == `OFS_FLAGS_3) begin
			rdata_d[7:0] = flags_3_q;
		end else if (paddr == `OFS_ENABLES_1) begin
			rdata_d[7:0] = enables_1_q;
		end else if (paddr == `OFS_ENABLES_2) begin
			rdata_d[7:0] = enables_2_q;
		end else if (paddr == `OFS_ENABLES_3) begin
			rdata_d[7:0] = enables_3_q;
		end else if (paddr == `OFS_PRIORITY_1) begin
			rdata_d[7:0] = priority_1_q;
		end else if (paddr == `OFS_PRIORITY_2) begin
			rdata_d[7:0] = priority_2_q;
		end else if (paddr == `OFS_PRIORITY_3) begin
			rdata_d[7:0] = priority_3_q;
		end else if (paddr == `OFS_CORE_CTRL) begin
			rdata_d[`CTRL_W-1:0] = ctrl_q;
		end else if (paddr == `OFS_STATUS) begin
			rdata_d[1:0] = {high_priority_request, low_priority_request};
		end else begin
			hit_d = 1'b0;
		end
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	// Ready is a flop: one wait state per transfer keeps every output registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			high_priority_request <= 1'b0;
			low_priority_request <= 1'b0;
		end else begin
			high_priority_request <= hi_d;
			low_priority_request <= lo_d;
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit_d;
			if (rd_acc) begin
				prdata <= rdata_d;
			end
		end
	end

endmodule

/* irq_bank_asserts.sv */
// Port assertions for the peripheral interrupt bank
`timescale 1ns/1ps
module irq_bank_asserts (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [7:0] buffer_state_1,
	input wire high_priority_request,
	input wire low_priority_request
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Answer comes one edge after the first access edge, for one cycle
	a_ready_on_time:
	assert property (psel && penable && !pready |=> pready) else $error("pready late");
	a_ready_pulse:
	assert property (pready |=> !pready) else $error("pready held");
	a_quiet_reset:
	assert property ($rose(presetn) |-> !high_priority_request && !low_priority_request)
		else $error("request out of reset");
	// Bits above 7 and unimplemented flag and enable positions always read as zero
	a_upper_zero:
	assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000) else $error("upper bits");
	a_group2_holes:
	assert property (pready && !pwrite && (paddr == 12'h004 || paddr == 12'h010)
		|-> prdata[5:4] == 2'h0) else $error("group 2 hole");
	a_group3_holes:
	assert property (pready && !pwrite && (paddr == 12'h008 || paddr == 12'h014)
		|-> (prdata[7:0] & 8'hCE) == 8'h00) else $error("group 3 hole");
	// Serial flags follow a buffer level that has stood still
	a_serial_mirror:
	assert property ($stable(buffer_state_1[5:4])[*4] ##0 pready && !pwrite && paddr == 12'h000
		|-> prdata[5:4] == buffer_state_1[5:4]) else $error("serial flag");
	a_unmapped_err:
	assert property (pready && paddr > 12'h028 |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access");
endmodule
bind peripheral_irq_flag_enable_bank irq_bank_asserts i_irq_bank_asserts (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .buffer_state_1,
	.high_priority_request, .low_priority_request);

/* periph_model.sv */
// Peripheral side: condition pulses and serial buffer levels
`timescale 1ns/1ps
module periph_model (
	input wire pclk,
	output logic [7:0] set_events_1,
	output logic [7:0] set_events_2,
	output logic [7:0] set_events_3,
	output logic [7:0] buffer_state_1,
	output logic [7:0] buffer_state_3
);
	// Quiet until commanded
	initial begin
		{set_events_1, set_events_2, set_events_3} = 24'h000000;
		{buffer_state_1, buffer_state_3} = 16'h0000;
	end
	// One-cycle condition, as overflow, match, capture or collision give
	task pulse(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		@(posedge pclk);
		{set_events_1, set_events_2, set_events_3} <= {a, b, c};
		@(posedge pclk);
		{set_events_1, set_events_2, set_events_3} <= 24'h000000;
	endtask
	// Bit 5 receive buffer holds data, bit 4 transmit buffer empty
	task levels(input logic [7:0] a, input logic [7:0] c);
		@(posedge pclk);
		buffer_state_1 <= a;
		buffer_state_3 <= c;
	endtask
endmodule

/* tb_peripheral_irq_flag_enable_bank.sv */
// Self-checking bench for the peripheral interrupt bank
`timescale 1ns/1ps
module tb_peripheral_irq_flag_enable_bank;
	logic pclk, presetn, psel, penable, pwrite, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, high_priority_request, low_priority_request;
	wire [7:0] set_events_1, set_events_2, set_events_3, buffer_state_1, buffer_state_3;
	int error_cnt, checks;
	peripheral_irq_flag_enable_bank i_peripheral_irq_flag_enable_bank (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .set_events_1,
		.set_events_2, .set_events_3, .buffer_state_1, .buffer_state_3,
		.high_priority_request, .low_priority_request);
	periph_model i_periph_model (.pclk, .set_events_1, .set_events_2, .set_events_3,
		.buffer_state_1, .buffer_state_3);
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	task summarize;
		if (error_cnt == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	// One APB transfer; the request stands until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
		if (n >= 20) begin
			error_cnt++;
			summarize();
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Requests settle two edges after the cause; three are allowed
	task rq(input logic [1:0] e);
		repeat (3) @(posedge pclk);
		chk({30'h0, high_priority_request, low_priority_request}, {30'h0, e});
	endtask
	task t_enables;
		wr(12'h00C, 32'hFF);
		wr(12'h010, 32'hFF);
		wr(12'h014, 32'hFF);
		rdc(12'h00C, 32'hFF);
		rdc(12'h010, 32'hCF);
		rdc(12'h014, 32'h31);
		for (int i = 3; i < 6; i++) wr(12'(i * 4), 32'h0);
	endtask
	// Every source fires with all enables off; then software clears
	task t_flags;
		i_periph_model.pulse(8'hFF, 8'hFF, 8'hFF);
		rdc(12'h000, 32'hCF);
		rdc(12'h004, 32'hCF);
		rdc(12'h008, 32'h01);
		for (int i = 0; i < 3; i++) wr(12'(i * 4), 32'h0);
		for (int i = 0; i < 3; i++) rdc(12'(i * 4), 32'h0);
	endtask
	task t_serial;
		i_periph_model.levels(8'h30, 8'h10);
		wr(12'h000, 32'h0);
		rdc(12'h000, 32'h30);
		rdc(12'h008, 32'h10);
		i_periph_model.levels(8'h00, 8'h20);
		rdc(12'h008, 32'h20);
		i_periph_model.levels(8'h00, 8'h00);
	endtask
	task t_gate;
		i_periph_model.pulse(8'h01, 8'h00, 8'h00);
		wr(12'h00C, 32'h1);
		wr(12'h024, 32'h1);
		rq(2'h0);
		wr(12'h024, 32'h3);
		rq(2'h1);
		rdc(12'h028, 32'h1);
		wr(12'h00C, 32'h0);
		rq(2'h0);
		rdc(12'h000, 32'h1);
		wr(12'h00C, 32'h1);
		wr(12'h024, 32'h5);
		rq(2'h2);
		wr(12'h018, 32'h0);
		rq(2'h0);
		wr(12'h024, 32'h7);
		rq(2'h1);
		wr(12'h000, 32'h0);
		rq(2'h0);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
		error_cnt = 0;
		checks = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) rdc(12'(i * 4), 32'h0);
		t_enables();
		t_flags();
		t_serial();
		t_gate();
		rdc(12'h040, 32'h0);
		chk({31'h0, er}, 32'h1);
		summarize();
	end
endmodule
